//--- hdl/slcc_link_ctrl.sv
// Static link sequencer, credit handshake, token streams and APB registers
// Functional notes
// R1: Static mode forwards tokens with no routing header and no lookup.
// R2: Static route enabled by writing only the top bit to route register.
// R3: Link direction field is programmed explicitly, default value one.
// R4: Destination word: node id, channel-end number, resource type 02.
// R5: Send hello tokens, then wait for credit before any data.
// R6: Far end answers hello with a credit token.
// R7: Reset, hello, wait about 100 us; repeat until credit is seen.
// R8: Data streams to the destination only after credit is held.
// R9: Control tokens interleave periodically with data, kept distinguishable.
// R10: Without credit the transmitter stalls, never drops, until credit/reset.
// R11: Disable, enable, reset release a stalled sender to credit request.
// R12: Receiver has no glitch filter; every token is taken as sent.
// R13: Receiver tells control from data tokens and counts each kind.
// R14: Receive timeout leaves streaming and returns to credit exchange.
// R15: Sequencer: direction, destination, route, handshake, then streaming.
// R16: Switch writes get a tens-of-milliseconds settle before handshake.
//
// Added by the designer: register access over APB and the register offsets.
`default_nettype none
module slcc_link_ctrl
   import slcc_pkg::*;
#(
   parameter int SETTLE_CYCLES = slcc_pkg::SETTLE_CYC, // Route settle
   parameter int HELLO_CYCLES = slcc_pkg::HELLO_CYC, // Wait after hello
   parameter int RX_TO_CYCLES = slcc_pkg::RX_TO_CYC // Receive timeout
) (
   input wire logic clock_i, // Clock, 125 MHz
   input wire logic reset_n_i, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   output logic irq_o, // Level interrupt
   input wire logic [7:0] tx_data_i, // User data token
   input wire logic tx_valid_i, // User data token valid
   output logic tx_ready_o, // User data token taken
   output logic [7:0] lnk_tx_data_o, // Token value to link
   output logic lnk_tx_ctrl_o, // Token is a control token
   output logic lnk_tx_valid_o, // Token offered to link
   input wire logic lnk_tx_ready_i, // Link takes token
   input wire logic [7:0] lnk_rx_data_i, // Received token value
   input wire logic lnk_rx_ctrl_i, // Received token is control
   input wire logic lnk_rx_valid_i, // Received token valid
   output logic [7:0] rx_data_o, // Last received data token
   output logic rx_valid_o, // Data token delivered, pulse
   input wire logic lnk_credit_i, // Credit token arrived, pulse
   output logic lnk_hello_o, // Send hello tokens, pulse
   output logic lnk_reset_o, // Reset link, pulse
   output logic lnk_enable_o, // Link enabled
   output logic [DIR_W-1:0] node_dir_o, // Node config direction field
   output logic [31:0] route_cfg_o, // Static route config register
   output logic [31:0] chan_dest_o, // Channel-end destination word
   output logic static_mode_o // Static mode, header suppressed
);
   // -------------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------------
   slcc_state_t st_q, st_d;
   logic start_q, dis_q;
   logic [DIR_W-1:0] dir_q, node_q;
   logic [31:0] dest_q, cdest_q, route_q;
   logic [15:0] period_q, tok_cnt_q;
   logic [INT_W-1:0] int_stat_q, int_mask_q, int_ev;
   logic [31:0] to_cnt_q, rx_data_cnt, rx_ctrl_cnt;
   logic credit_q, credit_clr, credit_ok;
   logic [7:0] rx_data_q;
   logic rx_valid_q;
   logic acc, wr, rd, mapped, wr_ctrl, soft_rst;
   logic wait_load, wait_done, to_load, to_done;
   logic send_ctrl, tx_fire, ctrl_fire;
   logic [31:0] wait_val;

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_PERIOD);
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   assign wr_ctrl = wr && (paddr == OFS_CTRL);
   assign soft_rst = wr_ctrl && pwdata[CTRL_RST_BIT];

   assign prdata = !rd ? 32'h0 :
      (paddr == OFS_CTRL) ? {30'h0, dis_q, start_q} :
      (paddr == OFS_DIR) ? {28'h0, dir_q} :
      (paddr == OFS_DEST) ? dest_q :
      (paddr == OFS_ROUTE) ? route_q :
      (paddr == OFS_NODE) ? {28'h0, node_q} :
      (paddr == OFS_STATUS) ? {23'h0, credit_q, st_q} :
      (paddr == OFS_INT_STAT) ? {29'h0, int_stat_q} :
      (paddr == OFS_INT_MASK) ? {29'h0, int_mask_q} :
      (paddr == OFS_RX_DATA) ? rx_data_cnt :
      (paddr == OFS_RX_CTRL) ? rx_ctrl_cnt :
      (paddr == OFS_TIMEOUTS) ? to_cnt_q :
      (paddr == OFS_PERIOD) ? {16'h0, period_q} : 32'h0;

   // -------------------------------------------------------------------
   // Software registers
   // -------------------------------------------------------------------
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         start_q <= 1'b0;
         dis_q <= 1'b0;
      end else if (wr_ctrl) begin
         start_q <= pwdata[CTRL_START_BIT];
         dis_q <= pwdata[CTRL_DIS_BIT]; // [R11]
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dir_q <= DIR_RESET;
         dest_q <= DEST_RESET;
         period_q <= PERIOD_RESET;
         int_mask_q <= '0;
      end else if (wr) begin
         if (paddr == OFS_DIR) dir_q <= pwdata[DIR_W-1:0];
         if (paddr == OFS_DEST) dest_q <= pwdata;
         if (paddr == OFS_PERIOD) period_q <= pwdata[15:0];
         if (paddr == OFS_INT_MASK) int_mask_q <= pwdata[INT_W-1:0];
      end
   end

   // -------------------------------------------------------------------
   // Interrupts
   // -------------------------------------------------------------------
   assign int_ev[INT_CREDIT_BIT] = lnk_credit_i;
   assign int_ev[INT_TIMEOUT_BIT] = to_done;
   assign int_ev[INT_CTOKEN_BIT] = lnk_rx_valid_i && lnk_rx_ctrl_i;
   assign irq_o = |(int_stat_q & int_mask_q);

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         int_stat_q <= '0;
      end else begin
         int_stat_q <= int_ev | (int_stat_q &
            ~((wr && paddr == OFS_INT_STAT) ? pwdata[INT_W-1:0] : '0));
      end
   end

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   assign wait_load = (st_d != st_q) &&
                      (st_d == ST_SETTLE || st_d == ST_WAITC);
   assign wait_val = (st_d == ST_SETTLE) ? 32'(SETTLE_CYCLES) :
                     32'(HELLO_CYCLES);

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (start_q) st_d = ST_DIR;
         end
         ST_DIR: begin
            st_d = ST_DEST; // [R15]
         end
         ST_DEST: begin
            st_d = ST_ROUTE;
         end
         ST_ROUTE: begin
            st_d = ST_SETTLE;
         end
         ST_SETTLE: begin
            if (wait_done) st_d = ST_HELLO; // [R16]
         end
         ST_HELLO: begin
            if (!dis_q) st_d = ST_WAITC; // [R5]
         end
         ST_WAITC: begin
            if (wait_done) begin
               st_d = credit_q ? ST_STREAM : ST_HELLO; // [R7]
            end
         end
         ST_STREAM: begin
            if (to_done) st_d = ST_HELLO; // [R14]
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
      // Disable or software reset drops back to the credit request
      if ((dis_q || soft_rst) && st_q inside {ST_WAITC, ST_STREAM}) begin
         st_d = ST_HELLO; // [R11] [R15]
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   slcc_timer u_wait (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .load_i(wait_load),
      .value_i(wait_val),
      .done_o(wait_done)
   );

   // -------------------------------------------------------------------
   // Switch configuration writes
   // -------------------------------------------------------------------
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         node_q <= '0;
         cdest_q <= 32'h0;
         route_q <= 32'h0;
      end else begin
         if (st_q == ST_DIR) node_q <= dir_q; // [R3]
         if (st_q == ST_DEST) cdest_q <= dest_q; // [R4]
         if (st_q == ST_ROUTE) route_q <= ROUTE_STATIC; // [R2]
      end
   end

   assign node_dir_o = node_q;
   assign chan_dest_o = cdest_q;
   assign route_cfg_o = route_q;
   assign static_mode_o = route_q[31]; // [R1]
   assign lnk_enable_o = !dis_q; // [R11]
   assign lnk_hello_o = (st_q == ST_HELLO) && !dis_q; // [R5] [R7]
   assign lnk_reset_o = ((st_q == ST_HELLO) && !dis_q) || soft_rst; // [R7]

   // -------------------------------------------------------------------
   // Credit
   // -------------------------------------------------------------------
   assign credit_clr = lnk_reset_o || dis_q || to_done;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         credit_q <= 1'b0;
      end else if (lnk_credit_i) begin
         credit_q <= 1'b1; // [R6]
      end else if (credit_clr) begin
         credit_q <= 1'b0; // [R14]
      end
   end

   // -------------------------------------------------------------------
   // Transmit stream
   // -------------------------------------------------------------------
   // Static mode sends data and control tokens only, no header ahead of them
   assign credit_ok = (st_q == ST_STREAM) && credit_q && static_mode_o;
   assign send_ctrl = (tok_cnt_q == period_q); // [R9]
   assign lnk_tx_valid_o = credit_ok && (send_ctrl || tx_valid_i); // [R10]
   assign lnk_tx_ctrl_o = send_ctrl; // [R9]
   assign lnk_tx_data_o = send_ctrl ? ACK_TOKEN : tx_data_i; // [R1]
   assign tx_ready_o = credit_ok && !send_ctrl && lnk_tx_ready_i; // [R8]
   assign tx_fire = tx_ready_o && tx_valid_i;
   assign ctrl_fire = lnk_tx_valid_o && send_ctrl && lnk_tx_ready_i;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tok_cnt_q <= 16'h0;
      end else if (st_q != ST_STREAM || ctrl_fire) begin
         tok_cnt_q <= 16'h0;
      end else if (tx_fire) begin
         tok_cnt_q <= tok_cnt_q + 16'h1; // [R9]
      end
   end

   // -------------------------------------------------------------------
   // Receive side
   // -------------------------------------------------------------------
   assign to_load = (st_q != ST_STREAM) || lnk_rx_valid_i;

   slcc_timer u_rx_to (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .load_i(to_load),
      .value_i(32'(RX_TO_CYCLES)),
      .done_o(to_done)
   );

   // Every token is taken as it arrives, with no filtering
   slcc_rx_count u_rx_cnt (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .tok_valid_i(lnk_rx_valid_i), // [R12]
      .tok_ctrl_i(lnk_rx_ctrl_i), // [R13]
      .data_cnt_o(rx_data_cnt),
      .ctrl_cnt_o(rx_ctrl_cnt)
   );

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_data_q <= 8'h0;
         rx_valid_q <= 1'b0;
         to_cnt_q <= 32'h0;
      end else begin
         rx_valid_q <= lnk_rx_valid_i && !lnk_rx_ctrl_i; // [R13]
         if (lnk_rx_valid_i && !lnk_rx_ctrl_i) rx_data_q <= lnk_rx_data_i;
         if (to_done) to_cnt_q <= to_cnt_q + 32'h1; // [R14]
      end
   end

   assign rx_data_o = rx_data_q;
   assign rx_valid_o = rx_valid_q;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   a_tx_credit: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      lnk_tx_valid_o |-> credit_q && st_q == ST_STREAM) // [R10]
      else $error("token offered without credit");
   a_route_word: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      st_q == ST_ROUTE |=> route_q == ROUTE_STATIC) // [R2]
      else $error("route register not static");
   a_dir_copy: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      st_q == ST_DIR |=> node_q == $past(dir_q)) // [R3]
      else $error("direction not programmed");
   a_dest_copy: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      st_q == ST_DEST |=> cdest_q == $past(dest_q)) // [R4]
      else $error("destination not programmed");
   a_hello_wait: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      lnk_hello_o && !soft_rst |=> st_q == ST_WAITC) // [R5]
      else $error("hello not followed by credit wait");
   a_stream_entry: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      st_q != ST_STREAM ##1 st_q == ST_STREAM |-> $past(credit_q)) // [R8]
      else $error("streaming entered without credit");
   a_ctrl_mark: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      lnk_tx_valid_o && lnk_tx_ctrl_o |-> tok_cnt_q == period_q
      && lnk_tx_data_o == ACK_TOKEN) // [R9]
      else $error("control token out of period");
   a_rx_timeout: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      to_done && !lnk_credit_i |=> !credit_q && st_q == ST_HELLO) // [R14]
      else $error("timeout did not return to handshake");
   a_disable_rel: assert property (@(posedge clock_i)
      disable iff (!reset_n_i)
      dis_q && st_q == ST_STREAM |=> st_q == ST_HELLO && !tx_ready_o) // [R11]
      else $error("disable did not release sender");
   a_settle_len: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      st_q == ST_ROUTE |=> st_q == ST_SETTLE [*2]) // [R16]
      else $error("settle interval cut short");
   a_rx_count: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      lnk_rx_valid_i && lnk_rx_ctrl_i |=>
      rx_ctrl_cnt == $past(rx_ctrl_cnt) + 32'h1
      && rx_data_cnt == $past(rx_data_cnt)) // [R13]
      else $error("control token miscounted");
endmodule
`default_nettype wire

//--- include/slcc_pkg.sv
// Constants, register map and state codes for the static link controller
`default_nettype none
package slcc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DIR = 8'h04;
   localparam logic [7:0] OFS_DEST = 8'h08;
   localparam logic [7:0] OFS_ROUTE = 8'h0C;
   localparam logic [7:0] OFS_NODE = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_INT_STAT = 8'h18;
   localparam logic [7:0] OFS_INT_MASK = 8'h1C;
   localparam logic [7:0] OFS_RX_DATA = 8'h20;
   localparam logic [7:0] OFS_RX_CTRL = 8'h24;
   localparam logic [7:0] OFS_TIMEOUTS = 8'h28;
   localparam logic [7:0] OFS_PERIOD = 8'h2C;
   // Field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_DIS_BIT = 1;
   localparam int CTRL_RST_BIT = 2;
   localparam int DIR_W = 4;
   localparam int INT_CREDIT_BIT = 0;
   localparam int INT_TIMEOUT_BIT = 1;
   localparam int INT_CTOKEN_BIT = 2;
   localparam int INT_W = 3;
   // Reset and fixed values
   localparam logic [DIR_W-1:0] DIR_RESET = 4'h1;
   localparam logic [31:0] DEST_RESET = 32'h80030002;
   localparam logic [31:0] ROUTE_STATIC = 32'h80000000;
   localparam logic [15:0] PERIOD_RESET = 16'h0010;
   localparam logic [7:0] ACK_TOKEN = 8'h03;
   // Timing
   localparam int CLK_MHZ = 125;
   localparam int SETTLE_MS = 50;
   localparam int HELLO_WAIT_US = 100;
   localparam int RX_TIMEOUT_US = 1000;
   localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
   localparam int HELLO_CYC = HELLO_WAIT_US * CLK_MHZ;
   localparam int RX_TO_CYC = RX_TIMEOUT_US * CLK_MHZ;
   // Sequencer states
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_DIR = 8'h02,
      ST_DEST = 8'h04,
      ST_ROUTE = 8'h08,
      ST_SETTLE = 8'h10,
      ST_HELLO = 8'h20,
      ST_WAITC = 8'h40,
      ST_STREAM = 8'h80
   } slcc_state_t;
endpackage
`default_nettype wire

//--- hdl/slcc_timer.sv
// Loadable down counter that pulses once on expiry
`default_nettype none
module slcc_timer (
   input wire logic clock_i, // Clock
   input wire logic reset_n_i, // Async reset, active low
   input wire logic load_i, // Load count, restarts the wait
   input wire logic [31:0] value_i, // Cycles to wait, at least 1
   output logic done_o // One-cycle pulse at expiry
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;

   assign cnt_d = load_i ? value_i :
                  (cnt_q != 32'h0) ? cnt_q - 32'h1 : 32'h0;
   assign done_o = !load_i && (cnt_q == 32'h1);

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= 32'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

//--- hdl/slcc_rx_count.sv
// Separate counters for received data and control tokens
`default_nettype none
module slcc_rx_count (
   input wire logic clock_i, // Clock
   input wire logic reset_n_i, // Async reset, active low
   input wire logic tok_valid_i, // Token consumed this cycle
   input wire logic tok_ctrl_i, // Consumed token is a control token
   output logic [31:0] data_cnt_o, // Data tokens seen
   output logic [31:0] ctrl_cnt_o // Control tokens seen
);
   logic [31:0] cnt_q [2];
   logic [1:0] hit;

   assign hit[0] = tok_valid_i && !tok_ctrl_i;
   assign hit[1] = tok_valid_i && tok_ctrl_i;

   for (genvar i = 0; i < 2; i++) begin : g_cnt
      always_ff @(posedge clock_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            cnt_q[i] <= 32'h0;
         end else if (hit[i]) begin
            cnt_q[i] <= cnt_q[i] + 32'h1;
         end
      end
   end

   assign data_cnt_o = cnt_q[0];
   assign ctrl_cnt_o = cnt_q[1];
endmodule
`default_nettype wire

//--- dv/slcc_peer_model.sv
// Far-side peer model: answers hello with credit, takes tokens with stalls
`default_nettype none
module slcc_peer_model (
   input wire logic clock_i, // Clock
   input wire logic reset_n_i, // Reset, active low
   input wire logic hello_i, // Hello from the local link
   input wire logic answer_i, // Peer present and answering
   input wire logic slow_i, // Peer stalls now and then
   output logic credit_o, // Credit token, pulse
   output logic ready_o // Peer takes a token
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] dly_q;
   logic [7:0] lfsr_q;
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dly_q <= 3'h0;
         lfsr_q <= 8'h5A;
         credit_o <= 1'h0;
      end else begin
         lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5]};
         credit_o <= (dly_q == 3'h1);
         if (hello_i && answer_i) dly_q <= 3'h3;
         else if (dly_q != 3'h0) dly_q <= dly_q - 3'h1;
      end
   end
   // Either token kind is taken alike; stalls come from the pattern
   assign ready_o = !slow_i || lfsr_q[0];
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the static link controller
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import slcc_pkg::*;
   localparam int PER = 3;
   logic clock_i = '0, reset_n_i = '0, psel = '0, penable = '0;
   logic pwrite = '0, pready, pslverr, irq_o, rd_err;
   logic [7:0] paddr = '0, tx_data_i = '0, lnk_rx_data_i = '0;
   logic [7:0] lnk_tx_data_o, rx_data_o;
   logic [31:0] pwdata = '0, prdata, rd, rnd, route_cfg_o, chan_dest_o;
   logic [31:0] seed = 32'h9A78;
   logic tx_valid_i = '0, tx_ready_o, lnk_tx_ctrl_o, lnk_tx_valid_o;
   logic lnk_tx_ready, lnk_rx_ctrl_i = '0, lnk_rx_valid_i = '0;
   logic rx_valid_o, credit, hello, lnk_reset_o, lnk_enable_o;
   logic static_mode_o, answer = '0, slow = '0, tx_on = '0, rx_on = '0;
   logic per_on = '1, granted = '0;
   logic [DIR_W-1:0] node_dir_o;
   int failures = 0, checks = 0, cycles = 0, hellos = 0, resets = 0;
   int since = 0, sent = 0, ctrls = 0, exp_d = 0, exp_c = 0, n, nh;
   logic [7:0] rxq[$];

   slcc_link_ctrl #(.SETTLE_CYCLES(20), .HELLO_CYCLES(10),
      .RX_TO_CYCLES(50)) slcc_link_ctrl_i (
      .clock_i, .reset_n_i, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq_o, .tx_data_i, .tx_valid_i,
      .tx_ready_o, .lnk_tx_data_o, .lnk_tx_ctrl_o, .lnk_tx_valid_o,
      .lnk_tx_ready_i(lnk_tx_ready), .lnk_rx_data_i, .lnk_rx_ctrl_i,
      .lnk_rx_valid_i, .rx_data_o, .rx_valid_o, .lnk_credit_i(credit),
      .lnk_hello_o(hello), .lnk_reset_o, .lnk_enable_o, .node_dir_o,
      .route_cfg_o, .chan_dest_o, .static_mode_o);
   slcc_peer_model slcc_peer_model_i (.clock_i, .reset_n_i,
      .hello_i(hello), .answer_i(answer), .slow_i(slow),
      .credit_o(credit), .ready_o(lnk_tx_ready));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'h1;
      do @(posedge clock_i); while (pready !== 1'h1);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      apb(1'h0, a, '0);
      chk(nm, e, rd);
   endtask
   task automatic wait_reg(input logic [7:0] a, input logic [31:0] s, m);
      rd = '0;
      for (int i = 0; i < 300 && (rd & m) !== s; i++) apb(1'h0, a, '0);
      chk("poll", s, rd & m);
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock, link drivers and monitors
   // ---------------------------------------------------------------
   always #4 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cycles++;
      if (cycles > 20000) begin
         failures++;
         give_verdict();
      end
   end
   always @(posedge clock_i) begin
      if (hello) hellos++;
      if (lnk_reset_o) resets++;
      if (credit) granted = 1'h1;
      if (lnk_tx_valid_o && lnk_tx_ready && lnk_tx_ctrl_o) begin
         chk("ctrl token", ACK_TOKEN, lnk_tx_data_o);
         if (per_on) chk("ctrl slot", PER, since);
         since = 0;
         ctrls++;
      end else if (lnk_tx_valid_o && lnk_tx_ready) begin
         chk("data token", tx_data_i, lnk_tx_data_o);
         chk("credit held", 1, granted);
         since++;
         sent++;
      end
      if (tx_valid_i) chk("accept", lnk_tx_valid_o && lnk_tx_ready &&
         !lnk_tx_ctrl_o, tx_ready_o);
      rnd = xs();
      lnk_rx_valid_i <= rx_on && rnd[0];
      lnk_rx_ctrl_i <= rnd[1] & rnd[2];
      lnk_rx_data_i <= rnd[15:8];
      if (rx_on && rnd[0] && rnd[1] && rnd[2]) exp_c++;
      else if (rx_on && rnd[0]) begin
         exp_d++;
         rxq.push_back(rnd[15:8]);
      end
      if (rx_valid_o && rxq.size() > 0)
         chk("rx data", rxq.pop_front(), rx_data_o);
      rnd = xs();
      if (tx_on && (!tx_valid_i || tx_ready_o)) begin
         tx_valid_i <= 1'h1;
         tx_data_i <= rnd[7:0];
      end
   end

   initial begin
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'h1;
      rchk("dir", OFS_DIR, 32'h1);
      rchk("dest", OFS_DEST, 32'h80030002);
      rchk("route", OFS_ROUTE, 32'h0);
      rchk("status", OFS_STATUS, 32'h1);
      rchk("period", OFS_PERIOD, 32'h10);
      rchk("unmapped", 8'h30, 32'h0);
      chk("slverr", 1, rd_err);
      apb(1'h1, OFS_PERIOD, PER);
      tx_on <= 1'h1;
      repeat (8) @(posedge clock_i);
      chk("stalled", 0, sent);
      chk("tx ready", 0, tx_ready_o);
      rx_on <= 1'h1;
      apb(1'h1, OFS_CTRL, 32'h1);
      repeat (80) @(posedge clock_i);
      chk("no credit", 0, sent);
      chk("retry", 1, hellos >= 2);
      chk("reset with hello", hellos, resets);
      chk("dir out", 1, node_dir_o);
      chk("route out", 32'h80000000, route_cfg_o);
      chk("static", 1, static_mode_o);
      chk("dest out", 32'h80030002, chan_dest_o);
      answer <= 1'h1;
      slow <= 1'h1;
      wait_reg(OFS_STATUS, 32'h80, 32'hFF);
      repeat (60) @(posedge clock_i);
      chk("streaming", 1, sent > 10 && ctrls > 2);
      rchk("int stat", OFS_INT_STAT, 32'h5);
      rx_on <= 1'h0;
      answer <= 1'h0;
      per_on <= 1'h0;
      repeat (3) @(posedge clock_i);
      rchk("rx data cnt", OFS_RX_DATA, exp_d);
      rchk("rx ctrl cnt", OFS_RX_CTRL, exp_c);
      apb(1'h1, OFS_INT_MASK, 32'h4);
      repeat (3) @(posedge clock_i);
      chk("irq set", 1, irq_o);
      apb(1'h1, OFS_INT_STAT, 32'h7);
      repeat (3) @(posedge clock_i);
      chk("irq clear", 0, irq_o);
      wait_reg(OFS_TIMEOUTS, 32'h1, 32'hFFFFFFFF);
      rchk("timeout int", OFS_INT_STAT, 32'h2);
      chk("irq masked", 0, irq_o);
      n = sent;
      repeat (30) @(posedge clock_i);
      chk("held after timeout", n, sent);
      apb(1'h1, OFS_CTRL, 32'h2);
      repeat (2) @(posedge clock_i);
      chk("disabled", 0, lnk_enable_o);
      rchk("status off", OFS_STATUS, 32'h20);
      n = hellos;
      repeat (30) @(posedge clock_i);
      chk("no hello", n, hellos);
      apb(1'h1, OFS_CTRL, 32'h0);
      n = resets;
      nh = hellos;
      apb(1'h1, OFS_CTRL, 32'h4);
      repeat (2) @(posedge clock_i);
      chk("link reset", 1, (resets - n) > (hellos - nh));
      answer <= 1'h1;
      rx_on <= 1'h1;
      wait_reg(OFS_STATUS, 32'h80, 32'hFF);
      n = sent;
      repeat (30) @(posedge clock_i);
      chk("resumed", 1, sent > n);
      apb(1'h1, OFS_CTRL, 32'h2);
      rchk("stream off", OFS_STATUS, 32'h20);
      chk("released", 0, tx_ready_o);
      give_verdict();
   end
endmodule
`default_nettype wire
